// >>> include/dram_timer_regs.svh
// Timing counts and widths for the DRAM access and refresh timer
`ifndef DRAM_TIMER_REGS_SVH
`define DRAM_TIMER_REGS_SVH
`define ADDR_W          10
`define ROW_LOW_CYC     4
`define PRECHG_LONG_CYC 4
`define PRECHG_SHORT_CYC 3
`define ACK_CYC         4
`define REF_DIV         64
`define REF_PEND_MAX    128
`endif

// >>> include/dram_timer_pkg.sv
// Types shared by the DRAM access and refresh timer
package dram_timer_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_HOLD,
        ST_REFRESH,
        ST_PRECHARGE
    } ctrl_state_t;
endpackage

// >>> include/refresh_link_if.sv
// Refresh tick and pending-count link between the timer and its refresh divider
`timescale 1ns/1ns
interface refresh_link_if;
    logic       tick;
    logic       take;
    logic [7:0] pending;
    modport divider (output tick, output pending, input take);
    modport ctrl    (input tick, input pending, output take);
endinterface

// >>> rtl/refresh_divider.sv
// Refresh clock divider and missed-refresh counter
`timescale 1ns/1ns
`include "dram_timer_regs.svh"
module refresh_divider #(
    parameter int DIV = `REF_DIV,
    parameter int MAX = `REF_PEND_MAX
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Raw refresh clock pin
    input  wire logic refresh_tick_clock,
    // Link to controller
    refresh_link_if.divider lnk
);
    initial begin
        if (DIV < 2 || DIV > 128 || MAX < 1 || MAX > 255) $error("refresh_divider: bad parameters");
    end

    logic       s1_reg, s2_reg, s3_reg;
    logic [6:0] div_reg;
    logic [7:0] pend_reg;
    wire        rcp_rise = s2_reg & ~s3_reg;
    wire        term     = rcp_rise && (div_reg == 7'(DIV - 1));
    wire        full     = (pend_reg == 8'(MAX));

    // Two-flop synchroniser, then edge detect on the second stage only
    always_ff @(posedge clk_sys) begin
        s1_reg <= refresh_tick_clock;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // Divide refresh clock edges by DIV
    always_ff @(posedge clk_sys) begin
        if (!rstn)
            div_reg <= 7'h00;
        else if (rcp_rise)
            div_reg <= term ? 7'h00 : div_reg + 7'h01;
    end

    // Pending count saturates; a new tick and a take in one cycle cancel, except at full where the take still counts down
    always_ff @(posedge clk_sys) begin
        if (!rstn)
            pend_reg <= 8'h00;
        else if (term && !full && !lnk.take)
            pend_reg <= pend_reg + 8'h01;
        else if (lnk.take && !(term && !full) && pend_reg != 8'h00)
            pend_reg <= pend_reg - 8'h01;
    end

    assign lnk.tick    = term;
    assign lnk.pending = pend_reg;

    pend_cap_a: assert property (@(posedge clk_sys) disable iff (!rstn) pend_reg <= 8'(MAX))
        else $error("pending refresh count above limit");
endmodule

// >>> rtl/dram_access_refresh_timer.sv
// DRAM access timing, address multiplexing and refresh arbitration
`timescale 1ns/1ns
`include "dram_timer_regs.svh"
module dram_access_refresh_timer
    import dram_timer_pkg::*;
#(
    parameter int AW = `ADDR_W
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Processor side
    input  wire logic          access_req_n,
    input  wire logic          page_mode_n,
    input  wire logic          addr_latch_en_n,
    input  wire logic [AW-1:0] row_addr_in,
    input  wire logic [AW-1:0] col_addr_in,
    output logic               grant,
    output logic               transfer_ack_n,
    output logic               transfer_ack_oe,
    // Configuration straps and refresh clock
    input  wire logic          row_hold_select,
    input  wire logic          precharge_length_select,
    input  wire logic          refresh_tick_clock,
    // DRAM side
    output logic               row_strobe_n,
    output logic               col_strobe_n,
    output logic [AW-1:0]      mem_addr_out
);
    initial begin
        if (AW < 1 || AW > 16) $error("dram_access_refresh_timer: bad address width");
    end

    refresh_link_if lnk ();

    refresh_divider u_refresh (
        .clk_sys            (clk_sys),
        .rstn               (rstn),
        .refresh_tick_clock (refresh_tick_clock),
        .lnk                (lnk)
    );

    // Pin synchronisers: every asynchronous pin passes two flops before use
    logic [1:0]    req_s_reg, page_s_reg, ale_s_reg, hold_s_reg, pre_s_reg;
    logic [AW-1:0] row_s1_reg, row_s2_reg, col_s1_reg, col_s2_reg;
    always_ff @(posedge clk_sys) begin
        req_s_reg  <= {req_s_reg[0], ~access_req_n};
        page_s_reg <= {page_s_reg[0], ~page_mode_n};
        ale_s_reg  <= {ale_s_reg[0], addr_latch_en_n};
        hold_s_reg <= {hold_s_reg[0], row_hold_select};
        pre_s_reg  <= {pre_s_reg[0], precharge_length_select};
        row_s1_reg <= row_addr_in;
        row_s2_reg <= row_s1_reg;
        col_s1_reg <= col_addr_in;
        col_s2_reg <= col_s1_reg;
    end
    wire req  = req_s_reg[1];
    wire page = page_s_reg[1];
    wire ale  = ale_s_reg[1];

    // Address latch: transparent while latch enable low, closed after rising edge
    logic          ale_d_reg;
    logic [AW-1:0] row_lat_reg, col_lat_reg;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ale_d_reg   <= 1'b0;
            row_lat_reg <= '0;
            col_lat_reg <= '0;
        end else begin
            ale_d_reg <= ale;
            if (!ale || !ale_d_reg) begin
                row_lat_reg <= row_s2_reg;
                col_lat_reg <= col_s2_reg;
            end
        end
    end
    // Latch output: live while transparent, held once closed
    wire [AW-1:0] row_eff = ale ? row_lat_reg : row_s2_reg;
    wire [AW-1:0] col_eff = ale ? col_lat_reg : col_s2_reg;

    // Main timing state
    ctrl_state_t st_reg, st_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic        page_acc_reg;
    logic        grant_reg, ras_reg, ack_reg, col_sel_reg, cas_rise_reg, cas_reg;
    logic [AW-1:0] rrow_reg;

    wire [2:0] pre_len  = pre_s_reg[1] ? 3'(`PRECHG_SHORT_CYC) : 3'(`PRECHG_LONG_CYC);
    wire       ref_due  = (lnk.pending != 8'h00);
    wire       start_acc = (st_reg == ST_IDLE) && req && !ref_due;
    wire       start_ref = (st_reg == ST_IDLE) && ref_due;
    wire       row_done = (cnt_reg == 3'(`ROW_LOW_CYC - 1));
    wire       page_end = page_acc_reg && (!page || !req);
    assign lnk.take = (st_reg == ST_REFRESH) && row_done;

    // Next state and counter
    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg + 3'h1;
        case (st_reg)
            ST_IDLE: begin
                cnt_next = 3'h0;
                if (start_ref)
                    st_next = ST_REFRESH;
                else if (start_acc)
                    st_next = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (!req || page_end) begin
                    st_next  = ST_PRECHARGE;
                    cnt_next = 3'h0;
                end else if (row_done && !page_acc_reg) begin
                    st_next  = ST_HOLD;
                    cnt_next = cnt_reg;
                end else if (row_done) begin
                    cnt_next = cnt_reg;
                end
            end
            ST_HOLD: begin
                cnt_next = cnt_reg;
                if (!req) begin
                    st_next  = ST_PRECHARGE;
                    cnt_next = 3'h0;
                end
            end
            ST_REFRESH: begin
                if (row_done) begin
                    st_next  = ST_PRECHARGE;
                    cnt_next = 3'h0;
                end
            end
            ST_PRECHARGE: begin
                if (cnt_reg == pre_len - 3'h2)
                    st_next = ST_IDLE; // one idle cycle completes the precharge
            end
            default: begin
                st_next  = ST_IDLE;
                cnt_next = 3'h0;
            end
        endcase
    end

    // Rising-edge registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_reg       <= ST_IDLE;
            cnt_reg      <= 3'h0;
            page_acc_reg <= 1'b0;
            grant_reg    <= 1'b0;
            ras_reg      <= 1'b0;
            ack_reg      <= 1'b0;
            col_sel_reg  <= 1'b0;
            rrow_reg     <= '0;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            if (start_acc)
                page_acc_reg <= page;
            grant_reg <= (st_next == ST_ACCESS) || (st_next == ST_HOLD);
            ras_reg   <= (st_next == ST_ACCESS) || (st_next == ST_REFRESH);
            ack_reg   <= (st_reg == ST_ACCESS || st_reg == ST_HOLD) && req &&
                         (cnt_reg == 3'(`ACK_CYC - 1)) && st_next != ST_PRECHARGE;
            // Column select from the first rising edge after row strobe: a full clock of row hold
            col_sel_reg <= (st_reg == ST_ACCESS || st_reg == ST_HOLD) && st_next != ST_PRECHARGE;
            if (lnk.take)
                rrow_reg <= rrow_reg + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    // Falling-edge stages give the half-clock column timing
    always_ff @(negedge clk_sys) begin
        if (!rstn) begin
            cas_rise_reg <= 1'b0;
            cas_reg      <= 1'b0;
        end else begin
            // Strobe stands while granted so it outlives the row strobe until the request ends
            cas_rise_reg <= grant_reg;
            cas_reg      <= grant_reg && cas_rise_reg;
        end
    end

    // Outputs: strobes release at once on request or page negation
    wire acc_live = grant_reg && req && !page_end;
    assign grant           = grant_reg && req;
    assign row_strobe_n    = !(ras_reg && (st_reg == ST_REFRESH || acc_live));
    assign col_strobe_n    = !(cas_reg && acc_live);
    assign transfer_ack_oe = (st_reg == ST_ACCESS || st_reg == ST_HOLD) && req;
    assign transfer_ack_n  = !(ack_reg && transfer_ack_oe);
    // Refresh counter shown before and through the refresh row strobe
    wire ref_addr = (st_reg == ST_REFRESH) || (st_reg == ST_IDLE && ref_due);
    // Short row hold switches to the column at the falling edge, half a clock after row strobe
    wire col_now = grant_reg && (col_sel_reg || (cas_rise_reg && hold_s_reg[1]));
    assign mem_addr_out = ref_addr ? rrow_reg : col_now ? col_eff : row_eff;

    // Checks
    ras_min_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(st_reg == ST_ACCESS) && !page_acc_reg |-> (st_reg != ST_IDLE) [*3] or
        ##[1:3] !req)
        else $error("row strobe shorter than minimum");
    pre_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(st_reg == ST_PRECHARGE) && !pre_s_reg[1] |-> !ras_reg [*4])
        else $error("precharge too short");
    ack_time_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(st_reg == ST_ACCESS) ##1 req [*3] |=> ack_reg || !req)
        else $error("acknowledge not at four clocks");
    ack_float_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !req |-> !transfer_ack_oe && !grant)
        else $error("acknowledge or grant held without request");
    ref_first_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_reg == ST_IDLE && ref_due |=> st_reg == ST_REFRESH)
        else $error("refresh did not win arbitration");
    ref_step_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        lnk.take |=> rrow_reg == $past(rrow_reg) + 1'b1)
        else $error("refresh row not advanced");
    ref_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_reg == ST_REFRESH |-> mem_addr_out == rrow_reg)
        else $error("refresh address not driven");
    page_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        st_reg == ST_ACCESS && page_acc_reg && req && page && row_done |=> st_reg == ST_ACCESS)
        else $error("page-mode row strobe ended early");
    rst_quiet_a: assert property (@(posedge clk_sys) !rstn |=> row_strobe_n && !grant && !transfer_ack_oe)
        else $error("outputs active after reset");

    acc_c:  cover property (@(posedge clk_sys) disable iff (!rstn) $fell(transfer_ack_n));
    page_c: cover property (@(posedge clk_sys) disable iff (!rstn) st_reg == ST_ACCESS && page_acc_reg && cnt_reg == 3'h3);
    ref_c:  cover property (@(posedge clk_sys) disable iff (!rstn) lnk.take ##[1:10] lnk.take);
    tick_c: cover property (@(posedge clk_sys) disable iff (!rstn) lnk.tick);
endmodule

// >>> sim/cpu_requester.sv
// Processor-side requester model driving the timer's access pins
`timescale 1ns/1ns
module cpu_requester (
    // Clock
    input  wire logic clk_sys,
    // Request and address pins
    output logic       access_req_n,
    output logic       page_mode_n,
    output logic       addr_latch_en_n,
    output logic [9:0] row_addr_in,
    output logic [9:0] col_addr_in
);
    // Idle pins: no request, latch transparent
    initial begin
        access_req_n = 1'h1;
        page_mode_n = 1'h1;
        addr_latch_en_n = 1'h0;
        row_addr_in = 10'h000;
        col_addr_in = 10'h000;
    end
    // Addresses go out one edge ahead and stay put until the request ends
    task automatic request(input logic [9:0] row, input logic [9:0] col, input logic page);
        @(posedge clk_sys);
        row_addr_in <= row;
        col_addr_in <= col;
        page_mode_n <= ~page;
        addr_latch_en_n <= 1'h0;
        @(posedge clk_sys);
        access_req_n <= 1'h1 ^ 1'h1;
    endtask
    // Unlatched addresses are not held past the request, so show garbage
    task automatic release_req();
        @(posedge clk_sys);
        access_req_n <= 1'h1;
        page_mode_n <= 1'h1;
        row_addr_in <= ~row_addr_in;
        col_addr_in <= ~col_addr_in;
    endtask
    // Column stepping in a page burst, latch left transparent
    task automatic step_col(input logic [9:0] col);
        @(posedge clk_sys);
        col_addr_in <= col;
    endtask
    // Row change while idle; latch closes three edges later when asked
    task automatic set_row(input logic [9:0] row, input logic latch);
        @(posedge clk_sys);
        row_addr_in <= row;
        repeat (3) @(posedge clk_sys);
        addr_latch_en_n <= latch;
    endtask
endmodule

// >>> sim/tb_dram_access_refresh_timer.sv
// Self-checking bench for the DRAM access and refresh timer
`timescale 1ns/1ns
module tb_dram_access_refresh_timer;
    logic       clk_sys = 1'h0;
    logic       rstn = 1'h0;
    logic       row_hold_select = 1'h0;
    logic       precharge_length_select = 1'h0;
    logic       refresh_tick_clock = 1'h0;
    logic       access_req_n, page_mode_n, addr_latch_en_n;
    logic       grant, transfer_ack_n, transfer_ack_oe, row_strobe_n, col_strobe_n;
    logic [9:0] row_addr_in, col_addr_in, mem_addr_out, prev_addr;
    logic [9:0] ref_row = 10'h000;
    logic [9:0] rows [2] = '{10'h0F0, 10'h3C3};
    logic [9:0] cols [2] = '{10'h30F, 10'h03C};
    int         n_fail = 0;
    int         checks_done = 0;
    int         prech;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    dram_access_refresh_timer dram_access_refresh_timer_i (.clk_sys(clk_sys), .rstn(rstn),
        .access_req_n(access_req_n), .page_mode_n(page_mode_n), .addr_latch_en_n(addr_latch_en_n),
        .row_addr_in(row_addr_in), .col_addr_in(col_addr_in), .grant(grant),
        .transfer_ack_n(transfer_ack_n), .transfer_ack_oe(transfer_ack_oe),
        .row_hold_select(row_hold_select), .precharge_length_select(precharge_length_select),
        .refresh_tick_clock(refresh_tick_clock), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .mem_addr_out(mem_addr_out));
    cpu_requester cpu_requester_i (.clk_sys(clk_sys), .access_req_n(access_req_n),
        .page_mode_n(page_mode_n), .addr_latch_en_n(addr_latch_en_n),
        .row_addr_in(row_addr_in), .col_addr_in(col_addr_in));

    // Case equality so an unknown never passes
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // Sample 1 ns after the edge so its updates have landed
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait for a row strobe level; prech counts cycles waited
    task automatic wait_ras(input logic v);
        // Step off the edge first so nothing is read in the time step that launches it
        #1;
        for (prech = 0; prech < 700 && row_strobe_n !== v; prech++) begin
            prev_addr = mem_addr_out;
            step(1);
        end
        if (row_strobe_n !== v) begin
            n_fail++;
            $display("ERROR %0t: row strobe wait ran out", $time);
            end_sim();
        end
    endtask
    // Refresh clock pulses, slow enough for the synchroniser
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys) refresh_tick_clock <= 1'h1;
            repeat (2) @(posedge clk_sys);
            refresh_tick_clock <= 1'h0;
            @(posedge clk_sys);
        end
    endtask

    initial begin
        step(10);
        check(row_strobe_n, 1'h1);
        check(col_strobe_n, 1'h1);
        check(grant, 1'h0);
        check(transfer_ack_oe, 1'h0);
        @(posedge clk_sys) rstn <= 1'h1;
        // Idle address path: transparent, then latched
        cpu_requester_i.set_row(10'h155, 1'h1);
        step(4);
        check(mem_addr_out, 10'h155);
        cpu_requester_i.set_row(10'h2AA, 1'h1);
        step(4);
        check(mem_addr_out, 10'h155);
        cpu_requester_i.set_row(10'h2AA, 1'h0);
        step(4);
        check(mem_addr_out, 10'h2AA);
        $display("test latch done");
        // Plain accesses with both hold and precharge selects
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            row_hold_select <= k[0];
            precharge_length_select <= k[0];
            cpu_requester_i.request(rows[k], cols[k], 1'h0);
            wait_ras(1'h0);
            check(grant, 1'h1);
            check(prev_addr, rows[k]);
            check(mem_addr_out, rows[k]);
            // Half a clock on: column only when the row hold is short
            @(negedge clk_sys);
            #1;
            check(mem_addr_out, k[0] ? cols[k] : rows[k]);
            step(1);
            check(col_strobe_n, 1'h1);
            check(mem_addr_out, cols[k]);
            step(1);
            check(col_strobe_n, 1'h0);
            check(mem_addr_out, cols[k]);
            step(1);
            check(transfer_ack_n, 1'h1);
            check(row_strobe_n, 1'h0);
            step(1);
            check(transfer_ack_n, 1'h0);
            check(transfer_ack_oe, 1'h1);
            check(row_strobe_n, 1'h1);
            step(3);
            check(grant, 1'h1);
            check(col_strobe_n, 1'h0);
            cpu_requester_i.release_req();
            step(3);
            check(grant, 1'h0);
            check(transfer_ack_oe, 1'h0);
        end
        $display("test access done");
        // Long page burst; refreshes missed meanwhile run back to back after it
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            precharge_length_select <= k[0];
            cpu_requester_i.request(rows[k], cols[k], 1'h1);
            wait_ras(1'h0);
            fork
                ticks(128);
                begin
                    step(8);
                    check(row_strobe_n, 1'h0);
                    cpu_requester_i.step_col(cols[1-k]);
                    step(4);
                    check(mem_addr_out, cols[1-k]);
                end
            join
            step(4);
            check(row_strobe_n, 1'h0);
            cpu_requester_i.release_req();
            repeat (2) begin
                wait_ras(1'h1);
                wait_ras(1'h0);
                check(prech >= (k == 0 ? 4 : 3), 1'h1);
                check(grant, 1'h0);
                check(prev_addr, ref_row);
                step(1);
                check(mem_addr_out, ref_row);
                ref_row++;
                step(2);
                check(row_strobe_n, 1'h0);
                step(1);
                check(row_strobe_n, 1'h1);
            end
            step(10);
            check(row_strobe_n, 1'h1);
        end
        $display("test page refresh done");
        // One tick short of a refresh, then the tick that makes it due
        ticks(63);
        step(20);
        check(row_strobe_n, 1'h1);
        ticks(1);
        wait_ras(1'h0);
        check(prev_addr, ref_row);
        $display("test refresh done");
        end_sim();
    end
endmodule
